// file: dv/hlsr_host.sv
`timescale 1ns/10ps
`default_nettype none
module hlsr_host (
  input wire logic mclk,
  input wire logic [15:0] readData,
  input wire logic readValid,
  output logic readStrobe,
  output logic [7:0] regAddr
);
  initial readStrobe = 1'b0;
  initial regAddr = 8'h00;
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge mclk) readStrobe = 1'b1;
    regAddr = a;
    @(negedge mclk) readStrobe = 1'b0;
    regAddr = ~a;
    d = readValid ? readData : 16'hXXXX;
  endtask
endmodule // hlsr_host
`default_nettype wire

// file: dv/hlsr_sva.sv
`timescale 1ns/10ps
`default_nettype none
module hlsr_sva (
  input wire logic mclk,
  input wire logic resetn,
  input wire hlsr_pkg::hlsr_sense_t senseIn,
  input wire hlsr_pkg::hlsr_flags_t flagsIn,
  input wire logic readStrobe,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] readData,
  input wire logic readValid,
  input wire logic addrError,
  input wire logic [15:0] livePinStatus,
  input wire logic [7:0] alertBusyFlags
);
  logic [3:0] up;
  always_ff @(posedge mclk)
    up <= resetn ? {up[2:0], 1'b1} : 4'h0;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence liveReq;
    readStrobe && regAddr == hlsr_pkg::LIVE_OFFSET;
  endsequence
  sequence liveAns;
    readValid && !addrError && readData == $past(livePinStatus);
  endsequence
  gate_mirror_a: assert property (up[3] |-> livePinStatus[10] == $past(senseIn.gateDrive, 3))
    else $error("gate bit");
  timer_mirror_a: assert property (up[3] |-> livePinStatus[9] == $past(senseIn.timerCapLow, 3))
    else $error("timer bit");
  uv_pin_a: assert property (up[3] |-> livePinStatus[5] != $past(senseIn.undervoltagePin, 3))
    else $error("uv bit");
  power_level_a: assert property (up[3] |-> livePinStatus[3] == $past(senseIn.powerLevel1, 3))
    else $error("power bit");
  short_flag_a: assert property (up[3] && $past(senseIn.gateDrive, 3) |-> !livePinStatus[14])
    else $error("short bit");
  alert_word_a: assert property (up[3] |-> alertBusyFlags[7:6] == ~$past(flagsIn, 3))
    else $error("alert word");
  live_read_a: assert property (liveReq |=> liveAns)
    else $error("live read");
  bad_read_a: assert property (readStrobe && regAddr == 8'hE6 |=> addrError && readData == 16'h0000)
    else $error("bad read");
endmodule // hlsr_sva
`default_nettype wire

// file: dv/hotswap_live_status_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
module hotswap_live_status_regs_test;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  hlsr_pkg::hlsr_sense_t sense = 12'h008;
  hlsr_pkg::hlsr_flags_t flags = 2'h0;
  logic sel = 1'b1;
  logic [12:0] ev = 13'h0000;
  logic wr = 1'b0;
  logic rs;
  logic [7:0] ra;
  logic [15:0] rd;
  logic rv;
  logic [15:0] d;
  int err_count = 0;
  int samples_checked = 0;
  hotswap_live_status_regs hotswap_live_status_regs_i (.mclk(mclk), .resetn(resetn), .senseIn(sense),
    .flagsIn(flags), .powerGoodClearSelect(sel), .shutdownEvent(ev), .readStrobe(rs), .writeStrobe(wr),
    .regAddr(ra), .writeData(16'hFFFF), .readData(rd), .readValid(rv), .addrError(), .livePinStatus(),
    .alertBusyFlags(), .shutdownCause());
  hlsr_host hlsr_host_i (.mclk(mclk), .readData(rd), .readValid(rv), .readStrobe(rs), .regAddr(ra));
  initial forever #2 mclk = ~mclk;
  function automatic logic [15:0] exp_live(hlsr_pkg::hlsr_sense_t s, logic h);
    exp_live = {h & !s.feedbackHigh, s.senseShort & !s.gateDrive, 3'h0, s.gateDrive, s.timerCapLow, h,
      s.enableActive, s.overcurrent, !s.undervoltagePin, s.overvoltagePin, s.powerLevel1, s.switchFault, 2'h0};
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic look(input logic [7:0] a);
    repeat (8) @(negedge mclk);
    hlsr_host_i.rd(a, d);
  endtask
  task automatic step(input logic [11:0] s, input logic h);
    sense = hlsr_pkg::hlsr_sense_t'(s);
    look(hlsr_pkg::LIVE_OFFSET);
    chk(d, exp_live(sense, h));
  endtask
  task automatic t_reset();
    hlsr_host_i.rd(hlsr_pkg::LIVE_OFFSET, d);
    chk(d, 16'h0000);
    hlsr_host_i.rd(hlsr_pkg::ALERT_OFFSET, d);
    chk(d, 16'h00F6);
    hlsr_host_i.rd(hlsr_pkg::CAUSE_OFFSET, d);
    chk(d, 16'h0000);
  endtask
  task automatic t_live();
    for (int i = 0; i < 12; i++)
    begin
      wr = 1'b1;
      @(negedge mclk) wr = 1'b0;
      step(12'h008 ^ (12'h001 << i), 1'b0);
    end
  endtask
  task automatic t_hold();
    sel = 1'b0;
    step(12'hE88, 1'b1);
    step(12'h688, 1'b1);
    step(12'h608, 1'b0);
    sel = 1'b1;
    step(12'hE88, 1'b1);
    step(12'h688, 1'b0);
  endtask
  task automatic t_alert();
    for (int i = 0; i < 4; i++)
    begin
      flags = hlsr_pkg::hlsr_flags_t'(i[1:0]);
      look(hlsr_pkg::ALERT_OFFSET);
      chk(d, {8'h00, !flags.alertDriven, !flags.busUnavailable, 6'h36});
    end
  endtask
  task automatic t_cause();
    for (int i = 0; i < 13; i++)
    begin
      ev = 13'h0001 << i;
      look(hlsr_pkg::CAUSE_OFFSET);
      chk(d, 16'(i + 1));
    end
    look(8'hE6);
    chk(d, 16'h0000);
  endtask
  initial
  begin
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
    t_reset();
    t_live();
    t_hold();
    t_alert();
    t_cause();
    conclude();
  end
  initial
  begin
    #20000;
    err_count++;
    conclude();
  end
endmodule // hotswap_live_status_regs_test
bind hotswap_live_status_regs hlsr_sva hlsr_sva_i (.mclk(mclk), .resetn(resetn), .senseIn(senseIn),
  .flagsIn(flagsIn), .readStrobe(readStrobe), .regAddr(regAddr), .readData(readData), .readValid(readValid),
  .addrError(addrError), .livePinStatus(livePinStatus), .alertBusyFlags(alertBusyFlags));
`default_nettype wire

// file: rtl/hlsr_pkg.sv
package hlsr_pkg;

  localparam logic [7:0] LIVE_OFFSET = 8'hE5;
  localparam logic [7:0] ALERT_OFFSET = 8'hEF;
  localparam logic [7:0] CAUSE_OFFSET = 8'hF1;

  localparam logic [15:0] LIVE_RESET = 16'h0000;
  localparam logic [7:0] ALERT_FIXED = 8'h36;
  localparam logic [7:0] ALERT_RESET = 8'hF6;
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [3:0] CAUSE_NONE = 4'h0;

  localparam logic [3:0] CAUSE_OPERATION = 4'h1;
  localparam logic [3:0] CAUSE_ENABLE = 4'h2;
  localparam logic [3:0] CAUSE_REBOOT = 4'h3;
  localparam logic [3:0] CAUSE_INTERNAL_SUPPLY_LOCKOUT = 4'h4;
  localparam logic [3:0] CAUSE_THERMAL_SHUTDOWN = 4'h5;
  localparam logic [3:0] CAUSE_MAIN_SUPPLY_LOCKOUT = 4'h6;
  localparam logic [3:0] CAUSE_OVERTEMP_FAULT = 4'h7;
  localparam logic [3:0] CAUSE_OVERCURRENT_FAULT = 4'h8;
  localparam logic [3:0] CAUSE_POWER_LEVEL2_FAULT = 4'h9;
  localparam logic [3:0] CAUSE_POWER_LEVEL1_FAULT = 4'hA;
  localparam logic [3:0] CAUSE_SWITCH_BAD_FAULT = 4'hB;
  localparam logic [3:0] CAUSE_INPUT_UNDER_FAULT = 4'hC;
  localparam logic [3:0] CAUSE_INPUT_OVER_FAULT = 4'hD;

  localparam int CAUSE_COUNT = 13;

  typedef struct packed {
    logic feedbackHigh;
    logic gateSourceHigh;
    logic drainSourceLow;
    logic senseShort;
    logic gateDrive;
    logic timerCapLow;
    logic enableActive;
    logic overcurrent;
    logic undervoltagePin;
    logic overvoltagePin;
    logic powerLevel1;
    logic switchFault;
  } hlsr_sense_t;

  localparam hlsr_sense_t SENSE_IDLE = 12'h008;

  typedef struct packed {
    logic alertDriven;
    logic busUnavailable;
  } hlsr_flags_t;

endpackage

// file: rtl/hotswap_live_status_regs.sv
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Output loss: feedback low while hold set.
// - Switch short: sense over 2mV, switch off.
// - Bit 10 mirrors gate drive pin level.
// - Bit 9 set when timer pin low.
// - Hold sets on feedback, gate, drain conditions.
// - Hold clears by feedback-low or switch-off.
// - Select 1 feedback-low clears; 0 switch-off clears.
// - Bit 7 shows enable pin active.
// - Bit 6 mirrors overcurrent comparator.
// - Bit 5 undervoltage low; bit 4 overvoltage high.
// - Bit 3 follows power limit, unlatched.
// - Bit 2 shows switch fault present.
// - Alert bit 7 reads 0 while alert driven.
// - Busy bit 6 reads 0 while unavailable.
// - Cause code in low nibble, upper zero.
// - Cause codes one through thirteen assigned.
module hotswap_live_status_regs (
  input wire logic mclk,
  input wire logic resetn,
  input wire hlsr_pkg::hlsr_sense_t senseIn,
  input wire hlsr_pkg::hlsr_flags_t flagsIn,
  input wire logic powerGoodClearSelect,
  input wire logic [hlsr_pkg::CAUSE_COUNT-1:0] shutdownEvent,
  input wire logic readStrobe,
  input wire logic writeStrobe,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] writeData,
  output logic [15:0] readData,
  output logic readValid,
  output logic addrError,
  output logic [15:0] livePinStatus,
  output logic [7:0] alertBusyFlags,
  output logic [7:0] shutdownCause
);

  hlsr_pkg::hlsr_sense_t senseMeta;
  hlsr_pkg::hlsr_sense_t senseSync;
  hlsr_pkg::hlsr_flags_t flagsMeta;
  hlsr_pkg::hlsr_flags_t flagsSync;
  logic selectMeta;
  logic selectSync;
  logic [hlsr_pkg::CAUSE_COUNT-1:0] eventMeta;
  logic [hlsr_pkg::CAUSE_COUNT-1:0] eventSync;
  logic [hlsr_pkg::CAUSE_COUNT-1:0] eventPrev;
  logic powerGoodHold;
  logic [3:0] lastOffReason;
  logic [3:0] next_lastOffReason;
  logic [15:0] next_live;
  logic [7:0] next_alert;
  logic [hlsr_pkg::CAUSE_COUNT-1:0] eventRise;
  logic holdSet;
  logic holdClear;

  // Maps a one-hot event position to its cause code.
  function automatic logic [3:0] causeCode(input int idx);
    case (idx)
      0: causeCode = hlsr_pkg::CAUSE_OPERATION;
      1: causeCode = hlsr_pkg::CAUSE_ENABLE;
      2: causeCode = hlsr_pkg::CAUSE_REBOOT;
      3: causeCode = hlsr_pkg::CAUSE_INTERNAL_SUPPLY_LOCKOUT;
      4: causeCode = hlsr_pkg::CAUSE_THERMAL_SHUTDOWN;
      5: causeCode = hlsr_pkg::CAUSE_MAIN_SUPPLY_LOCKOUT;
      6: causeCode = hlsr_pkg::CAUSE_OVERTEMP_FAULT;
      7: causeCode = hlsr_pkg::CAUSE_OVERCURRENT_FAULT;
      8: causeCode = hlsr_pkg::CAUSE_POWER_LEVEL2_FAULT;
      9: causeCode = hlsr_pkg::CAUSE_POWER_LEVEL1_FAULT;
      10: causeCode = hlsr_pkg::CAUSE_SWITCH_BAD_FAULT;
      11: causeCode = hlsr_pkg::CAUSE_INPUT_UNDER_FAULT;
      12: causeCode = hlsr_pkg::CAUSE_INPUT_OVER_FAULT;
      default: causeCode = hlsr_pkg::CAUSE_NONE;
    endcase
  endfunction

  // Tells whether an offset belongs to one of the three status words.
  function automatic logic isMapped(input logic [7:0] addr);
    case (addr)
      hlsr_pkg::LIVE_OFFSET: isMapped = 1'b1;
      hlsr_pkg::ALERT_OFFSET: isMapped = 1'b1;
      hlsr_pkg::CAUSE_OFFSET: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  // Brings the comparator and pin levels into the clock domain at their idle levels.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      senseMeta <= hlsr_pkg::SENSE_IDLE;
      senseSync <= hlsr_pkg::SENSE_IDLE;
    end
    else
    begin
      senseMeta <= senseIn;
      senseSync <= senseMeta;
    end
  end

  // Brings the alert and busy indications into the clock domain.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      flagsMeta <= '0;
      flagsSync <= '0;
    end
    else
    begin
      flagsMeta <= flagsIn;
      flagsSync <= flagsMeta;
    end
  end

  // Brings the hold clear select into the clock domain.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      selectMeta <= 1'b1;
      selectSync <= 1'b1;
    end
    else
    begin
      selectMeta <= powerGoodClearSelect;
      selectSync <= selectMeta;
    end
  end

  // Brings the shutdown events into the clock domain and keeps their last level.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      eventMeta <= '0;
      eventSync <= '0;
      eventPrev <= '0;
    end
    else
    begin
      eventMeta <= shutdownEvent;
      eventSync <= eventMeta;
      eventPrev <= eventSync;
    end
  end

  // Finds the rising edge of every shutdown event.
  genvar g;
  generate
    for (g = 0; g < hlsr_pkg::CAUSE_COUNT; g++)
    begin : gen_rise
      assign eventRise[g] = eventSync[g] && !eventPrev[g];
    end
  endgenerate

  // Decodes the set and clear conditions of the power-good hold.
  always_comb
  begin
    holdSet = senseSync.feedbackHigh && senseSync.gateSourceHigh && senseSync.drainSourceLow;
    holdClear = selectSync ? !senseSync.feedbackHigh : !senseSync.gateDrive;
  end

  // Power-good hold: set wins over clear when both occur together.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      powerGoodHold <= 1'b0;
    end
    else if (holdSet)
    begin
      powerGoodHold <= 1'b1;
    end
    else if (holdClear)
    begin
      powerGoodHold <= 1'b0;
    end
  end

  // The newest rising shutdown event records its cause; higher positions win ties.
  always_comb
  begin
    next_lastOffReason = lastOffReason;
    for (int i = 0; i < hlsr_pkg::CAUSE_COUNT; i++)
    begin
      if (eventRise[i])
      begin
        next_lastOffReason = causeCode(i);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      lastOffReason <= hlsr_pkg::CAUSE_NONE;
    end
    else
    begin
      lastOffReason <= next_lastOffReason;
    end
  end

  // Assembles the live status word; reserved bits read zero.
  always_comb
  begin
    next_live = 16'h0000;
    next_live[15] = powerGoodHold && !senseSync.feedbackHigh;
    next_live[14] = senseSync.senseShort && !senseSync.gateDrive;
    next_live[10] = senseSync.gateDrive;
    next_live[9] = senseSync.timerCapLow;
    next_live[8] = powerGoodHold;
    next_live[7] = senseSync.enableActive;
    next_live[6] = senseSync.overcurrent;
    next_live[5] = !senseSync.undervoltagePin;
    next_live[4] = senseSync.overvoltagePin;
    next_live[3] = senseSync.powerLevel1;
    next_live[2] = senseSync.switchFault;
  end

  // Alert and busy word with fixed reserved pattern.
  always_comb
  begin
    next_alert = hlsr_pkg::ALERT_FIXED;
    next_alert[7] = !flagsSync.alertDriven;
    next_alert[6] = !flagsSync.busUnavailable;
  end

  // Live status word image; bus writes never reach it.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      livePinStatus <= hlsr_pkg::LIVE_RESET;
    end
    else
    begin
      livePinStatus <= next_live;
    end
  end

  // Alert and busy word image; bus writes never reach it.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      alertBusyFlags <= hlsr_pkg::ALERT_RESET;
    end
    else
    begin
      alertBusyFlags <= next_alert;
    end
  end

  // Shutdown cause image; the upper nibble always reads zero.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      shutdownCause <= hlsr_pkg::CAUSE_RESET;
    end
    else
    begin
      shutdownCause <= {4'h0, lastOffReason};
    end
  end

  // Read answer strobes: one cycle after the request.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      readValid <= 1'b0;
      addrError <= 1'b0;
    end
    else
    begin
      readValid <= readStrobe;
      addrError <= readStrobe && !isMapped(regAddr);
    end
  end

  // Read data: holds until the next read; writes are accepted and discarded.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      readData <= 16'h0000;
    end
    else if (readStrobe)
    begin
      case (regAddr)
        hlsr_pkg::LIVE_OFFSET: readData <= livePinStatus;
        hlsr_pkg::ALERT_OFFSET: readData <= {8'h00, alertBusyFlags};
        hlsr_pkg::CAUSE_OFFSET: readData <= {8'h00, shutdownCause};
        default: readData <= 16'h0000;
      endcase
    end
    else if (writeStrobe && (writeData == writeData))
    begin
      readData <= readData;
    end
  end

endmodule // hotswap_live_status_regs

`default_nettype wire
